/* rtl/gbd_cfg.svh */
/*
  register map, field positions, reset values and fixed figures of the gear backlash diagnosis block.
  assumes: included by bare name from the package and the design files.
*/
`ifndef GBD_CFG_SVH
`define GBD_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define GBD_OFS_GEAR      12'h000
`define GBD_OFS_NOMINAL   12'h004
`define GBD_OFS_MULT      12'h008
`define GBD_OFS_CTRL      12'h00c
`define GBD_OFS_STATUS    12'h010
`define GBD_OFS_ESTIMATE  12'h014
`define GBD_OFS_THRESH    12'h018
`define GBD_OFS_IRQ_STAT  12'h01c
`define GBD_OFS_IRQ_CLR   12'h020
`define GBD_OFS_IRQ_EN    12'h024

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define GBD_GEAR_RESET    32'h0000_0000
`define GBD_PARAM_RESET   16'h0000
`define GBD_CTRL_START    0
`define GBD_CTRL_LEAVE    1
`define GBD_ST_BUSY       0
`define GBD_ST_TEST       1
`define GBD_ST_WARN       2
`define GBD_ST_ERR_LSB    16
`define GBD_IRQ_DONE      0
`define GBD_IRQ_ERROR     1
`define GBD_IRQ_WARN      2
`define GBD_IRQ_W         3

// ----------------------------------------------------------------
// figures
// ----------------------------------------------------------------
`define GBD_STOP_RPM      16'h0014
`define GBD_CENTIDEG_REV  16'h8ca0
`define GBD_MULT_DIV      32'h0000_000a
`define GBD_ERR_NONE      16'h0000
`define GBD_ERR_SPEED     16'hc001
`define GBD_ERR_LINEAR    16'hc002
`define GBD_ERR_AXIS      16'hc003
`define GBD_ERR_BUSY      16'hc004
`define GBD_ERR_ABORT     16'hc005
`define GBD_ERR_LIMCTL    16'hc007

`endif

/* rtl/gbd_pkg.sv */
/*
  types shared by the gear backlash diagnosis design files.
  assumes: nothing beyond the cfg header.
*/
`include "gbd_cfg.svh"

package gbd_pkg;

  typedef struct packed {
    logic [15:0] den;
    logic [15:0] num;
  } gbd_gear_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } gbd_apb_req_type;

  typedef enum logic [4:0] {
    GBD_IDLE = 5'h01,
    GBD_DIV  = 5'h02,
    GBD_FWD  = 5'h04,
    GBD_REV  = 5'h08,
    GBD_RET  = 5'h10
  } gbd_motion_state_type;

endpackage

/* rtl/gbd_motion.sv */
/*
  own to-and-fro motion command and lost-motion measurement for backlash estimation.
  assumes: fb_pos comes from encoder logic on sys_clk; start is a one-cycle pulse.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gbd_cfg.svh"

module gbd_motion #(
  parameter int PPR_LOG2 = 22,
  parameter int STEP_DIV = 4,
  parameter int POS_W    = 32
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rstn,
  input  wire logic                       start,
  input  wire logic                       abort,
  input  wire gbd_pkg::gbd_gear_type      gear,
  input  wire logic signed [POS_W-1:0]    fb_pos,
  output logic signed [POS_W-1:0]         cmd_pos,
  output logic                            active,
  output logic                            done,
  output logic                            aborted,
  output logic [POS_W-1:0]                lost_max
);
  localparam int DIV_W = PPR_LOG2 + 16;
  localparam logic [DIV_W-1:0] TWO_REV = DIV_W'(2) << PPR_LOG2;

  gbd_pkg::gbd_motion_state_type state, next_state;
  logic signed [POS_W-1:0] next_cmd_pos, offset, next_offset, travel, next_travel, fb_prev;
  logic [POS_W-1:0]        lost, next_lost, next_lost_max;
  logic [DIV_W-1:0]        quo, next_quo;
  logic [16:0]             rem, next_rem, sh_rem;
  logic [7:0]              cnt, next_cnt;
  logic [15:0]             tick, next_tick;
  logic                    measuring, next_measuring, up, next_up, step, moved;
  logic                    next_done, next_aborted;

  always_comb
  begin
    next_state = state;
    next_cmd_pos = cmd_pos;
    next_offset = offset;
    next_travel = travel;
    next_lost = lost;
    next_lost_max = lost_max;
    next_quo = quo;
    next_rem = rem;
    next_cnt = cnt;
    next_measuring = measuring;
    next_up = up;
    next_done = 1'b0;
    next_aborted = 1'b0;
    sh_rem = {rem[15:0], quo[DIV_W-1]};
    step = (tick == 16'(STEP_DIV - 1));
    next_tick = step ? 16'h0000 : tick + 16'h0001;
    moved = up ? (fb_pos > fb_prev) : (fb_pos < fb_prev);
    // lost motion: command steps issued after a reversal before the load side follows
    if (measuring && lost > lost_max)
      next_lost_max = lost;
    if (measuring && moved)
      next_measuring = 1'b0;
    unique case (state)
      gbd_pkg::GBD_IDLE:
      begin
        if (start)
        begin
          next_cmd_pos = fb_pos;
          next_offset = '0;
          next_lost_max = '0;
          next_measuring = 1'b0;
          next_up = 1'b1;
          if (gear.num == 16'h0000 || gear.den == 16'h0000)
          begin
            next_travel = POS_W'(TWO_REV);
            next_state = gbd_pkg::GBD_FWD;
          end
          else
          begin
            next_quo = DIV_W'(gear.den) << PPR_LOG2;
            next_rem = 17'h00000;
            next_cnt = 8'h00;
            next_state = gbd_pkg::GBD_DIV;
          end
        end
      end
      gbd_pkg::GBD_DIV:
      begin
        // serial divide: travel = one revolution scaled by den/num, never above two revolutions
        if (sh_rem >= {1'b0, gear.num})
        begin
          next_rem = sh_rem - {1'b0, gear.num};
          next_quo = {quo[DIV_W-2:0], 1'b1};
        end
        else
        begin
          next_rem = sh_rem;
          next_quo = {quo[DIV_W-2:0], 1'b0};
        end
        next_cnt = cnt + 8'h01;
        if (abort)
        begin
          next_state = gbd_pkg::GBD_IDLE;
          next_aborted = 1'b1;
        end
        else if (cnt == 8'(DIV_W - 1))
        begin
          if (next_quo > TWO_REV)
            next_travel = POS_W'(TWO_REV);
          else if (next_quo == '0)
            next_travel = POS_W'(1);
          else
            next_travel = POS_W'(next_quo);
          next_state = gbd_pkg::GBD_FWD;
        end
      end
      gbd_pkg::GBD_FWD, gbd_pkg::GBD_REV, gbd_pkg::GBD_RET:
      begin
        if (abort)
        begin
          next_state = gbd_pkg::GBD_IDLE;
          next_aborted = 1'b1;
        end
        else if (step)
        begin
          if ((state == gbd_pkg::GBD_FWD && offset == travel) ||
              (state == gbd_pkg::GBD_REV && offset == -travel))
          begin
            next_state = (state == gbd_pkg::GBD_FWD) ? gbd_pkg::GBD_REV : gbd_pkg::GBD_RET;
            next_up = (state != gbd_pkg::GBD_FWD);
            next_measuring = 1'b1;
            next_lost = '0;
          end
          else if (state == gbd_pkg::GBD_RET && offset == '0)
          begin
            next_state = gbd_pkg::GBD_IDLE;
            next_done = 1'b1;
          end
          else
          begin
            next_offset = up ? offset + POS_W'(1) : offset - POS_W'(1);
            next_cmd_pos = up ? cmd_pos + POS_W'(1) : cmd_pos - POS_W'(1);
            if (next_measuring)
              next_lost = lost + POS_W'(1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state <= gbd_pkg::GBD_IDLE;
      cmd_pos <= '0;
      offset <= '0;
      travel <= '0;
      lost <= '0;
      lost_max <= '0;
      quo <= '0;
      rem <= '0;
      cnt <= '0;
      tick <= '0;
      measuring <= 1'b0;
      up <= 1'b1;
      fb_prev <= '0;
      active <= 1'b0;
      done <= 1'b0;
      aborted <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cmd_pos <= next_cmd_pos;
      offset <= next_offset;
      travel <= next_travel;
      lost <= next_lost;
      lost_max <= next_lost_max;
      quo <= next_quo;
      rem <= next_rem;
      cnt <= next_cnt;
      tick <= next_tick;
      measuring <= next_measuring;
      up <= next_up;
      fb_prev <= fb_pos;
      active <= (next_state != gbd_pkg::GBD_IDLE);
      done <= next_done;
      aborted <= next_aborted;
    end
  end

  zero_gear_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    state == gbd_pkg::GBD_IDLE && start && gear.num == 16'h0000 |=> travel == POS_W'(TWO_REV))
    else $error("zero gear field did not select two revolutions");
endmodule // gbd_motion

`default_nettype wire

/* rtl/gbd_top.sv */
/*
  gear backlash diagnosis: start checks, own motion, backlash estimate, threshold and warning, apb registers.
  assumes: apb master on sys_clk; speed, motor type, axis activity, encoder position and external command come
  from logic on sys_clk; forced stop and travel limit pins are asynchronous.
*/
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "gbd_cfg.svh"

module gbd_top #(
  parameter int PPR_LOG2 = 22,
  parameter int STEP_DIV = 4,
  parameter int POS_W    = 32
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rstn,
  input  wire gbd_pkg::gbd_apb_req_type   apb_req,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [15:0]                motor_speed,
  input  wire logic                       motor_linear,
  input  wire logic                       other_axis_running,
  input  wire logic                       limits_on_controller,
  input  wire logic                       forced_stop_input,
  input  wire logic                       upper_travel_limit,
  input  wire logic                       lower_travel_limit,
  input  wire logic signed [POS_W-1:0]    ext_pos_cmd,
  input  wire logic signed [POS_W-1:0]    fb_pos,
  output logic signed [POS_W-1:0]         pos_cmd,
  output logic                            own_command,
  output logic                            machine_diagnosis_warning,
  output logic                            busy,
  output logic                            test_mode,
  output logic                            irq
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_raw, sync1, sync2, sync3, pin_filt, next_pin_filt;
  assign pin_raw = {lower_travel_limit, upper_travel_limit, forced_stop_input};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : pin_sync
      // a change counts only once the second and third stages agree
      always_comb
      begin
        next_pin_filt[g] = (sync2[g] == sync3[g]) ? sync3[g] : pin_filt[g];
      end
      always_ff @(posedge sys_clk)
      begin
        if (!rstn)
        begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          pin_filt[g] <= 1'b0;
        end
        else
        begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          pin_filt[g] <= next_pin_filt[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction

  logic wr_now, rd_now, start_req, leave_req, mapped;
  always_comb
  begin
    wr_now = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;
    rd_now = apb_req.psel && apb_req.penable && !pready;
    start_req = wr_now && hit(apb_req.paddr, `GBD_OFS_CTRL) && apb_req.pwdata[`GBD_CTRL_START];
    leave_req = wr_now && hit(apb_req.paddr, `GBD_OFS_CTRL) && apb_req.pwdata[`GBD_CTRL_LEAVE];
    mapped = apb_req.paddr[1:0] == 2'h0 && apb_req.paddr <= `GBD_OFS_IRQ_EN;
  end

  // ----------------------------------------------------------------
  // registers and control
  // ----------------------------------------------------------------
  gbd_pkg::gbd_gear_type gear, next_gear;
  logic [15:0] nominal, next_nominal, mult, next_mult, err_code, next_err_code;
  logic [31:0] estimate, next_estimate, thresh, next_thresh, next_prdata;
  logic [`GBD_IRQ_W-1:0] irq_stat, next_irq_stat, irq_en, next_irq_en, events;
  logic next_pready, next_pslverr, next_busy, next_test_mode, next_warn, next_irq, start_go, next_start_go;
  logic signed [POS_W-1:0] motion_cmd, next_pos_cmd;
  logic [POS_W-1:0] lost_max;
  logic [47:0] lash_scaled;
  logic motion_active, motion_done, motion_aborted, fault_stop;

  assign fault_stop = |pin_filt;
  assign lash_scaled = 48'(lost_max) * 48'(`GBD_CENTIDEG_REV);

  always_comb
  begin
    next_gear = gear;
    next_nominal = nominal;
    next_mult = mult;
    next_irq_en = irq_en;
    next_err_code = err_code;
    next_estimate = estimate;
    next_warn = machine_diagnosis_warning;
    next_busy = busy;
    next_test_mode = test_mode;
    next_start_go = 1'b0;
    events = '0;
    if (wr_now && hit(apb_req.paddr, `GBD_OFS_GEAR))
      next_gear = apb_req.pwdata;
    if (wr_now && hit(apb_req.paddr, `GBD_OFS_NOMINAL))
      next_nominal = apb_req.pwdata[15:0];
    if (wr_now && hit(apb_req.paddr, `GBD_OFS_MULT))
      next_mult = apb_req.pwdata[15:0];
    if (wr_now && hit(apb_req.paddr, `GBD_OFS_IRQ_EN))
      next_irq_en = apb_req.pwdata[`GBD_IRQ_W-1:0];
    // start acceptance, first failing check reports
    if (start_req)
    begin
      events[`GBD_IRQ_ERROR] = 1'b1;
      if (busy)
        next_err_code = `GBD_ERR_BUSY;
      else if (motor_linear)
        next_err_code = `GBD_ERR_LINEAR;
      else if (other_axis_running)
        next_err_code = `GBD_ERR_AXIS;
      else if (limits_on_controller)
        next_err_code = `GBD_ERR_LIMCTL;
      else if (motor_speed >= `GBD_STOP_RPM)
        next_err_code = `GBD_ERR_SPEED;
      else
      begin
        events[`GBD_IRQ_ERROR] = 1'b0;
        next_err_code = `GBD_ERR_NONE;
        next_busy = 1'b1;
        next_test_mode = 1'b1;
        next_warn = 1'b0;
        next_start_go = 1'b1;
      end
    end
    else if (leave_req && !busy)
      next_test_mode = 1'b0;
    if (motion_aborted)
    begin
      next_busy = 1'b0;
      next_err_code = `GBD_ERR_ABORT;
      events[`GBD_IRQ_ERROR] = 1'b1;
    end
    if (motion_done)
    begin
      next_busy = 1'b0;
      next_estimate = lash_scaled[PPR_LOG2 +: 32];
      next_warn = (thresh != 32'h0) && (next_estimate > thresh);
      events[`GBD_IRQ_DONE] = 1'b1;
      events[`GBD_IRQ_WARN] = next_warn;
    end
    // multiplier zero means twice the nominal, all in 0.01 degree
    if (mult == 16'h0000)
      next_thresh = {15'h0000, nominal, 1'b0};
    else
      next_thresh = (32'(nominal) * 32'(mult)) / `GBD_MULT_DIV;
    // set wins over a clear in the same cycle
    next_irq_stat = irq_stat;
    if (wr_now && hit(apb_req.paddr, `GBD_OFS_IRQ_CLR))
      next_irq_stat = irq_stat & ~apb_req.pwdata[`GBD_IRQ_W-1:0];
    next_irq_stat = next_irq_stat | events;
    next_irq = |(irq_stat & irq_en);
    // external commands are ignored while busy or parked in test state
    next_pos_cmd = (next_busy || next_test_mode) ? motion_cmd : ext_pos_cmd;
  end

  always_comb
  begin
    next_pready = rd_now;
    next_pslverr = rd_now && !mapped;
    next_prdata = 32'h0000_0000;
    if (rd_now)
    begin
      unique case (1'b1)
        hit(apb_req.paddr, `GBD_OFS_GEAR):     next_prdata = gear;
        hit(apb_req.paddr, `GBD_OFS_NOMINAL):  next_prdata = {16'h0000, nominal};
        hit(apb_req.paddr, `GBD_OFS_MULT):     next_prdata = {16'h0000, mult};
        hit(apb_req.paddr, `GBD_OFS_STATUS):
          next_prdata = {err_code, 13'h0000, machine_diagnosis_warning, test_mode, busy};
        hit(apb_req.paddr, `GBD_OFS_ESTIMATE): next_prdata = estimate;
        hit(apb_req.paddr, `GBD_OFS_THRESH):   next_prdata = thresh;
        hit(apb_req.paddr, `GBD_OFS_IRQ_STAT): next_prdata = {29'h0000_0000, irq_stat};
        hit(apb_req.paddr, `GBD_OFS_IRQ_EN):   next_prdata = {29'h0000_0000, irq_en};
        default:                               next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      gear <= `GBD_GEAR_RESET;
      nominal <= `GBD_PARAM_RESET;
      mult <= `GBD_PARAM_RESET;
      err_code <= `GBD_ERR_NONE;
      estimate <= 32'h0000_0000;
      thresh <= 32'h0000_0000;
      irq_stat <= '0;
      irq_en <= '0;
      irq <= 1'b0;
      machine_diagnosis_warning <= 1'b0;
      busy <= 1'b0;
      test_mode <= 1'b0;
      own_command <= 1'b0;
      start_go <= 1'b0;
      pos_cmd <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      gear <= next_gear;
      nominal <= next_nominal;
      mult <= next_mult;
      err_code <= next_err_code;
      estimate <= next_estimate;
      thresh <= next_thresh;
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      irq <= next_irq;
      machine_diagnosis_warning <= next_warn;
      busy <= next_busy;
      test_mode <= next_test_mode;
      own_command <= next_busy || next_test_mode;
      start_go <= next_start_go;
      pos_cmd <= next_pos_cmd;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // motion engine
  // ----------------------------------------------------------------
  gbd_motion #(
    .PPR_LOG2 (PPR_LOG2),
    .STEP_DIV (STEP_DIV),
    .POS_W    (POS_W)
  ) motion (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .start    (start_go),
    .abort    (fault_stop),
    .gear     (gear),
    .fb_pos   (fb_pos),
    .cmd_pos  (motion_cmd),
    .active   (motion_active),
    .done     (motion_done),
    .aborted  (motion_aborted),
    .lost_max (lost_max)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  speed_reject_a : assert property (start_req && !busy && !motor_linear && !other_axis_running &&
    !limits_on_controller && motor_speed >= `GBD_STOP_RPM |=> !busy && err_code == `GBD_ERR_SPEED)
    else $error("start accepted while motor was turning");
  linear_reject_a : assert property (start_req && !busy && motor_linear |=>
    !busy && err_code == `GBD_ERR_LINEAR && irq_stat[`GBD_IRQ_ERROR])
    else $error("start accepted with a linear motor");
  axis_reject_a : assert property (start_req && !busy && !motor_linear && other_axis_running |=>
    !busy ##1 !motion_active)
    else $error("start accepted while another axis runs");
  limit_code_a : assert property (start_req && !busy && !motor_linear && !other_axis_running &&
    limits_on_controller |=> err_code == `GBD_ERR_LIMCTL)
    else $error("limit assignment code wrong");
  thresh_calc_a : assert property (##1 thresh == (($past(mult) == 16'h0000) ?
    {15'h0000, $past(nominal), 1'b0} : (32'($past(nominal)) * 32'($past(mult))) / `GBD_MULT_DIV))
    else $error("threshold value wrong");
  warn_decide_a : assert property (motion_done |=> machine_diagnosis_warning ==
    (thresh != 32'h0 && estimate > thresh))
    else $error("warning does not match estimate against threshold");
  busy_hold_a : assert property (busy && start_req |=> busy && err_code == `GBD_ERR_BUSY)
    else $error("start taken while busy");
  test_stay_a : assert property (test_mode && !leave_req |=> test_mode && own_command)
    else $error("test state left without host reset");
  own_drive_a : assert property (busy ##1 busy |-> pos_cmd == $past(motion_cmd))
    else $error("external command reached the motor during estimation");

  accepted_c : cover property (start_req && !busy ##[1:20] motion_active);
  finished_c : cover property (motion_done ##1 machine_diagnosis_warning);
  aborted_c  : cover property (motion_aborted);
  left_c     : cover property (test_mode ##1 !test_mode);
endmodule // gbd_top

`default_nettype wire

/* verification/gbd_motor_model.sv */
/*
  motor and encoder on the far side: the shaft follows the command through a lash band.
  assumes: pos_cmd is registered on sys_clk; stall holds the shaft to model a slow load.
*/
`timescale 1ns/100ps
`default_nettype none

module gbd_motor_model #(
  parameter int LASH = 1
) (
  input  wire logic               sys_clk,
  input  wire logic               stall,
  input  wire logic signed [31:0] pos_cmd,
  output logic signed [31:0]      fb_pos
);
  // the shaft moves only once the band is taken up, so every reversal costs steps
  initial fb_pos = '0;
  always @(posedge sys_clk)
  begin
    if (!stall && pos_cmd > fb_pos + LASH)
      fb_pos <= pos_cmd - LASH;
    else if (!stall && pos_cmd < fb_pos - LASH)
      fb_pos <= pos_cmd + LASH;
  end
endmodule // gbd_motor_model
`default_nettype wire

/* verification/testbench.sv */
/*
  self-checking bench of gbd_top over apb, with the lash motor model on the far side.
  assumes: rtl header and package compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gbd_cfg.svh"

module testbench;
  logic                     sys_clk = 0;
  logic                     rstn = 0;
  gbd_pkg::gbd_apb_req_type req = '0;
  logic [31:0]              prdata;
  logic signed [31:0]       pmax, fb, pc, ext = '0;
  logic [15:0]              spd = '0;
  logic                     pready, pslverr, own, warn, busy, tm, irq;
  logic                     lin = 0, oth = 0, lim = 0, stop = 0, stall = 0;
  logic [33:0]              q[$];
  int                       n_errors = 0, samples_checked = 0;

  always #20 sys_clk = ~sys_clk;

  gbd_top #(.PPR_LOG2(4), .STEP_DIV(1)) DUT (.sys_clk(sys_clk), .rstn(rstn), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .motor_speed(spd), .motor_linear(lin), .other_axis_running(oth),
    .limits_on_controller(lim), .forced_stop_input(stop), .upper_travel_limit(1'b0),
    .lower_travel_limit(1'b0), .ext_pos_cmd(ext), .fb_pos(fb), .pos_cmd(pc), .own_command(own),
    .machine_diagnosis_warning(warn), .busy(busy), .test_mode(tm), .irq(irq));
  gbd_motor_model #(.LASH(1)) motor (.sys_clk(sys_clk), .stall(stall), .pos_cmd(pc), .fb_pos(fb));

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic complete_run(input logic hung);
    if (hung)
      n_errors++;
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge sys_clk)
  begin
    if (pready === 1'b1)
    begin
      cmp({31'h0, pslverr}, {31'h0, q[0][32]});
      if (q[0][33])
        cmp(prdata, q[0][31:0]);
      void'(q.pop_front());
    end
    if (busy === 1'b1 && pc > pmax)
      pmax <= pc;
    stall <= 1'($urandom % 2);
  end

  // ----------------------------------------------------------------
  // apb master and estimation runs
  // ----------------------------------------------------------------
  task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
    int i;
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    q.push_back(e);
    @(posedge sys_clk);
    req.penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1)
      complete_run(1);
    req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ap(1'b1, a, d, {2'b00, 32'h0});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    ap(1'b0, a, 32'h0, {2'b10, e});
  endtask

  task automatic go(input logic [31:0] travel, input logic again);
    int i;
    logic signed [31:0] base;
    // the run starts from wherever the shaft rests, so the excursion is measured from there
    base = fb;
    pmax = fb;
    wr(`GBD_OFS_CTRL, 32'h1);
    @(posedge sys_clk);
    cmp({31'h0, own}, 32'h1);
    if (again)
    begin
      wr(`GBD_OFS_CTRL, 32'h1);
      rd(`GBD_OFS_STATUS, 32'hc004_0003);
    end
    for (i = 0; busy === 1'b1 && i < 3000; i++)
      @(posedge sys_clk);
    if (i == 3000)
      complete_run(1);
    cmp(pmax - base, travel);
  endtask

  initial
  begin
    logic [15:0] codes [4];
    logic [31:0] nom, mul;
    codes = '{16'hc002, 16'hc003, 16'hc007, 16'hc001};
    void'($urandom(35));
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(`GBD_OFS_GEAR, 32'h0);
    ap(1'b0, 12'h028, 32'h0, {2'b01, 32'h0});
    wr(`GBD_OFS_IRQ_EN, 32'h2);
    for (int k = 0; k < 4; k++)
    begin
      {lin, oth, lim} <= 3'b100 >> k;
      spd <= (k == 3) ? 16'h0014 : 16'($urandom % 20);
      wr(`GBD_OFS_CTRL, 32'h1);
      rd(`GBD_OFS_STATUS, {codes[k], 16'h0});
      cmp({31'h0, irq}, 32'h1);
      wr(`GBD_OFS_IRQ_CLR, 32'h7);
    end
    // one axis at a time, standing still
    spd <= 16'($urandom % 20);
    rd(`GBD_OFS_IRQ_STAT, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    wr(`GBD_OFS_NOMINAL, 32'h0);
    rd(`GBD_OFS_THRESH, 32'h0);
    wr(`GBD_OFS_NOMINAL, 32'h1);
    rd(`GBD_OFS_THRESH, 32'h2);
    wr(`GBD_OFS_IRQ_EN, 32'h1);
    go(32'd32, 1'b0);
    rd(`GBD_OFS_STATUS, 32'h6);
    cmp({31'h0, irq}, 32'h1);
    wr(`GBD_OFS_IRQ_CLR, 32'h7);
    wr(`GBD_OFS_GEAR, 32'h0001_0002);
    rd(`GBD_OFS_GEAR, 32'h0001_0002);
    nom = $urandom % 65536;
    mul = 1 + $urandom % 200;
    wr(`GBD_OFS_NOMINAL, nom);
    wr(`GBD_OFS_MULT, mul);
    rd(`GBD_OFS_THRESH, nom * mul / 10);
    wr(`GBD_OFS_NOMINAL, 32'hffff);
    wr(`GBD_OFS_MULT, 32'h0);
    wr(`GBD_OFS_IRQ_EN, 32'h0);
    go(32'd8, 1'b1);
    cmp({31'h0, warn}, 32'h0);
    cmp({31'h0, tm}, 32'h1);
    rd(`GBD_OFS_IRQ_STAT, 32'h3);
    cmp({31'h0, irq}, 32'h0);
    // forced stop during the divide: run ends early, test state stays
    wr(`GBD_OFS_CTRL, 32'h1);
    stop <= 1'b1;
    ext <= $urandom;
    repeat (8) @(posedge sys_clk);
    stop <= 1'b0;
    rd(`GBD_OFS_STATUS, 32'hc005_0002);
    cmp({31'h0, pc == ext}, 32'h0);
    wr(`GBD_OFS_CTRL, 32'h2);
    repeat (2) @(posedge sys_clk);
    cmp({31'h0, tm}, 32'h0);
    cmp(pc, ext);
    complete_run(0);
  end
endmodule // testbench
`default_nettype wire
